// File: dv/uhcs_props.sv
// Checker for the host command and status register bank.
// Assumes binding by name onto the top module's ports.
`timescale 1ns/1ps
module uhcs_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic listSizeCapable,
    input wire logic cacheEvicted,
    input wire logic hostAccessFault,
    input wire logic [13:0] frameCounter,
    input wire logic runEnable,
    input wire logic [7:0] interruptThreshold,
    input wire logic [1:0] frameListSize,
    input wire logic [9:0] listIndex,
    input wire logic evictRequest,
    input wire logic coreReset,
    input wire logic companionOwnership
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // Plain command write, not one that starts a controller reset
    wire cmdWr = regWrite && regAddr == 8'h20 && !regWdata[1] && !coreReset;

    // Run bit is one flop deep before the registered output
    a_run_start: assert property (cmdWr && regWdata[0] && !hostAccessFault
        |-> ##2 runEnable)
        else $error("run bit not taken");
    a_fault_stop: assert property (hostAccessFault |-> ##2 !runEnable)
        else $error("run kept after fault");
    a_itc_write: assert property (cmdWr
        |=> interruptThreshold == $past(regWdata[23:16]))
        else $error("threshold not written");
    a_fls_locked: assert property (cmdWr && !listSizeCapable
        |=> $stable(frameListSize))
        else $error("list size changed without capability");
    a_list_index: assert property (frameListSize == 2'h0 && $stable(frameListSize)
        && $stable(frameCounter) |-> listIndex == frameCounter[12:3])
        else $error("list index bits wrong");
    a_reset_ends: assert property ($rose(coreReset) |-> ##[2:8] !coreReset)
        else $error("controller reset never ends");
    a_owner_back: assert property (coreReset |=> companionOwnership)
        else $error("ports not handed to companions");
    a_unmapped_zero: assert property (regRead && regAddr == 8'h28
        |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    a_door_clear: assert property (evictRequest && cacheEvicted |=> !evictRequest)
        else $error("doorbell not cleared");

    c_run: cover property (cmdWr && regWdata[0]);
    c_fault: cover property (hostAccessFault && runEnable);
    c_reset: cover property ($rose(coreReset));
endmodule : uhcs_props

bind usb_host_command_status uhcs_props uhcs_props_i (.*);

// File: dv/usb_host_command_status_test.sv
// Self-checking bench for the host command and status register bank.
// Assumes the design and its bound checker are compiled with it.
`timescale 1ns/1ps
module usb_host_command_status_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic rdDone = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic listSizeCapable = 1'b0;
    logic pipelineIdle = 1'b0;
    logic asyncRunning = 1'b0;
    logic periodicRunning = 1'b0;
    logic [13:0] frameCounter = 14'h0;
    logic [4:0] ev = 5'h0;
    logic emptyIn = 1'b0;
    int base;
    logic runEnable;
    logic companionOwnership;
    logic [7:0] interrupt_threshold;
    logic [31:0] expQ[$];
    logic [7:0] code;
    int seed;
    int miscompares = 0;
    int nChecks = 0;

    always #2 core_clk = ~core_clk;

    usb_host_command_status usb_host_command_status_i (
        .core_clk(core_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .listSizeCapable(listSizeCapable), .pipelineIdle(pipelineIdle),
        .asyncRunning(asyncRunning), .periodicRunning(periodicRunning), .asyncEmpty(emptyIn),
        .cacheEvicted(ev[4]), .hostAccessFault(ev[3]), .frameCounter(frameCounter),
        .transferDone(ev[0]), .transferError(ev[1]), .portChange(ev[2]),
        .runEnable(runEnable), .asyncEnable(), .periodicEnable(), .interruptThreshold(interrupt_threshold),
        .frameListSize(), .listIndex(), .evictRequest(), .coreReset(),
        .companionOwnership(companionOwnership)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    // Expectation queued now, compared by the read monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge core_clk);
        regRead <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge core_clk);
        ev <= 5'h0;
        @(posedge core_clk);
    endtask : pulse

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    always @(posedge core_clk)
    begin
        if (rdDone)
            check(regRdata, expQ.pop_front());
        rdDone <= regRead;
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        seed = 32'hafdd;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(8'h20, 32'h0008_0000);
        rd(8'h24, 32'h0000_1000);
        rd(8'h28, 32'h0);
        $display("reset values done");
        // Every legal threshold, starting at a random code
        base = $unsigned($random(seed)) % 7;
        for (int i = 0; i < 7; i++)
        begin
            code = 8'h01 << ((base + i) % 7);
            wr(8'h20, {8'h0, code, 16'h0});
            rd(8'h20, {8'h0, code, 16'h0});
            check({24'h0, interrupt_threshold}, {24'h0, code});
        end
        $display("threshold done");
        wr(8'h20, {8'h0, code, 16'h0004});
        rd(8'h20, {8'h0, code, 16'h0000});
        listSizeCapable <= 1'b1;
        wr(8'h20, {8'h0, code, 16'h0004});
        rd(8'h20, {8'h0, code, 16'h0004});
        frameCounter <= 14'h1000;
        repeat (2) @(posedge core_clk);
        rd(8'h24, 32'h0000_1008);
        wr(8'h24, 32'h8);
        rd(8'h24, 32'h0000_1000);
        for (int b = 0; b < 3; b++)
        begin
            pulse(b);
            wr(8'h24, 32'h0);
            rd(8'h24, 32'h0000_1000 | (32'h1 << b));
            wr(8'h24, 32'h1 << b);
            rd(8'h24, 32'h0000_1000);
        end
        $display("list size and flags done");
        wr(8'h20, {8'h0, code, 16'h0005});
        rd(8'h24, 32'h0);
        check({31'h0, runEnable}, 32'h1);
        wr(8'h20, {8'h0, code, 16'h0004});
        rd(8'h24, 32'h0);
        pipelineIdle <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h24, 32'h0000_1000);
        wr(8'h20, {8'h0, code, 16'h0005});
        pulse(3);
        rd(8'h20, {8'h0, code, 16'h0004});
        rd(8'h24, 32'h0000_1010);
        wr(8'h24, 32'h10);
        $display("run and halt done");
        asyncRunning <= 1'b1;
        periodicRunning <= 1'b1;
        emptyIn <= 1'b1;
        wr(8'h20, {8'h0, code, 16'h0034});
        rd(8'h24, 32'h0000_f000);
        // Doorbell only once the async schedule reports active
        wr(8'h20, {8'h0, code, 16'h00f4});
        rd(8'h20, {8'h0, code, 16'h0074});
        pulse(4);
        rd(8'h20, {8'h0, code, 16'h0034});
        rd(8'h24, 32'h0000_f020);
        wr(8'h24, 32'h0000_f020);
        rd(8'h24, 32'h0000_f020);
        emptyIn <= 1'b0;
        $display("doorbell done");
        wr(8'h20, {8'h0, code, 16'h0002});
        rd(8'h20, 32'h0008_0002);
        repeat (8) @(posedge core_clk);
        rd(8'h20, 32'h0008_0000);
        rd(8'h24, 32'h0000_1000);
        check({31'h0, companionOwnership}, 32'h1);
        $display("controller reset done");
        wrap_up();
    end
endmodule : usb_host_command_status_test

// File: rtl/uhcs_cfg.svh
// Constants for the host command and status register bank.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef UHCS_CFG_SVH
`define UHCS_CFG_SVH
`define UHCS_CMD_OFFSET 8'h20
`define UHCS_STS_OFFSET 8'h24
`define UHCS_CMD_RS 0
`define UHCS_CMD_HCRST 1
`define UHCS_CMD_FLS_LO 2
`define UHCS_CMD_PSE 4
`define UHCS_CMD_ASE 5
`define UHCS_CMD_DOOR 6
`define UHCS_CMD_LIGHT 7
`define UHCS_CMD_ITC_LO 16
`define UHCS_STS_XFER 0
`define UHCS_STS_XERR 1
`define UHCS_STS_PORT 2
`define UHCS_STS_ROLL 3
`define UHCS_STS_SYSERR 4
`define UHCS_STS_ADV 5
`define UHCS_STS_EMPTY 13
`define UHCS_STS_HALT 12
`define UHCS_STS_PACT 14
`define UHCS_STS_AACT 15
`define UHCS_ITC_RESET 8'h08
`define UHCS_FLS_RESET 2'h0
`define UHCS_RST_NS 16
`define UHCS_RST_CYCLES ((`UHCS_RST_NS + 3) / 4)
`endif

// File: rtl/uhcs_pkg.sv
// Types for the host command and status register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package uhcs_pkg;
    typedef enum logic [1:0] {
        UHCS_HALTED = 2'b00,
        UHCS_RUNNING = 2'b01,
        UHCS_DRAINING = 2'b10
    } uhcs_run_t;
endpackage : uhcs_pkg

// File: rtl/uhcs_reset_seq.sv
// Controller reset sequencer: holds a reset pulse for a fixed count.
// Assumes start is a one-cycle request on core_clk.
`timescale 1ns/1ps
`include "uhcs_cfg.svh"
module uhcs_reset_seq (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    output logic busy
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    wire logic done = busy && (count_reg == 8'h00);

    assign count_next = start ? 8'((`UHCS_RST_CYCLES) - 1) :
                        (busy && !done) ? count_reg - 8'h01 : count_reg;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busy <= 1'b0;
            count_reg <= 8'h00;
        end
        else
        begin
            busy <= start ? 1'b1 : (done ? 1'b0 : busy);
            count_reg <= count_next;
        end
    end
endmodule : uhcs_reset_seq

// File: rtl/usb_host_command_status.sv
// Command and status registers of the high speed host controller.
// Assumes a simple one-cycle register port and scheduler handshakes.
`timescale 1ns/1ps
`include "uhcs_cfg.svh"
//
// Contract
// - Threshold resets to 08h, sets interrupt rate
// - Light reset reads busy until done; not implemented here, bit 7 always reads zero
// - Doorbell sets advance flag, then self-clears
// - Async enable resets zero, gates async schedule
// - Periodic enable resets zero, gates periodic schedule
// - List size writable only with capability
// - Controller reset reinitialises all operational state
// - No port reset; ports return to companions
// - Hardware clears reset bit; zero ignored
// - Clearing run finishes pipeline then halts
// - Event flags clear by writing one; the advance flag here ignores the write and clears only on reset
// - Reserved bits written with reset values
// - Async active bit follows enable, delayed
// - Periodic active bit follows enable, delayed
// - Halted resets one, clear while running
// - Rollover flag on index wrap per size
// - Events recorded regardless of enables
// - Index bits N to 3 form list index
module usb_host_command_status (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic listSizeCapable,
    input wire logic pipelineIdle,
    input wire logic asyncRunning,
    input wire logic periodicRunning,
    input wire logic asyncEmpty,
    input wire logic cacheEvicted,
    input wire logic hostAccessFault,
    input wire logic [13:0] frameCounter,
    input wire logic transferDone,
    input wire logic transferError,
    input wire logic portChange,
    output logic runEnable,
    output logic asyncEnable,
    output logic periodicEnable,
    output logic [7:0] interruptThreshold,
    output logic [1:0] frameListSize,
    output logic [9:0] listIndex,
    output logic evictRequest,
    output logic coreReset,
    output logic companionOwnership
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    wire logic cmdWrite = regWrite && hit(regAddr, `UHCS_CMD_OFFSET);
    wire logic stsWrite = regWrite && hit(regAddr, `UHCS_STS_OFFSET);
    wire logic cmdRead = hit(regAddr, `UHCS_CMD_OFFSET);
    wire logic stsRead = hit(regAddr, `UHCS_STS_OFFSET);

    logic runReg;
    logic doorbell_reg;
    logic [5:0] events_reg;
    logic [5:0] events_next;
    logic halted_reg;
    logic asyncAct_reg;
    logic periodicAct_reg;
    logic empty_reg;
    logic lastWrap_reg;
    logic resetBusy;
    logic resetStart;
    uhcs_pkg::uhcs_run_t runState_reg;
    uhcs_pkg::uhcs_run_t runState_next;

    // Reset bit starts the sequencer; a written zero has no effect
    assign resetStart = cmdWrite && regWdata[`UHCS_CMD_HCRST] && !resetBusy;
    wire logic softReset = reset || resetBusy;

    uhcs_reset_seq uhcs_reset_seq_i (
        .core_clk(core_clk),
        .reset(reset),
        .start(resetStart),
        .busy(resetBusy)
    );

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    wire logic doorbellSet = cmdWrite && regWdata[`UHCS_CMD_DOOR];
    wire logic doorbellDone = doorbell_reg && cacheEvicted;
    wire logic runFromWrite = cmdWrite ? regWdata[`UHCS_CMD_RS] : runReg;
    // Fault forces stop so no further descriptors run
    wire logic runNext = hostAccessFault ? 1'b0 : runFromWrite;

    always_ff @(posedge core_clk)
    begin
        if (softReset)
        begin
            runReg <= 1'b0;
            asyncEnable <= 1'b0;
            periodicEnable <= 1'b0;
            interruptThreshold <= `UHCS_ITC_RESET;
            frameListSize <= `UHCS_FLS_RESET;
            doorbell_reg <= 1'b0;
        end
        else
        begin
            runReg <= runNext;
            doorbell_reg <= doorbellSet ? 1'b1 : (doorbellDone ? 1'b0 : doorbell_reg);
            if (cmdWrite)
            begin
                asyncEnable <= regWdata[`UHCS_CMD_ASE];
                periodicEnable <= regWdata[`UHCS_CMD_PSE];
                interruptThreshold <= regWdata[`UHCS_CMD_ITC_LO +: 8];
                if (listSizeCapable)
                begin
                    frameListSize <= regWdata[`UHCS_CMD_FLS_LO +: 2];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Run and halt sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        runState_next = runState_reg;
        case (runState_reg)
            uhcs_pkg::UHCS_HALTED:
                if (runReg)
                    runState_next = uhcs_pkg::UHCS_RUNNING;
            uhcs_pkg::UHCS_RUNNING:
                if (!runReg)
                    runState_next = uhcs_pkg::UHCS_DRAINING;
            uhcs_pkg::UHCS_DRAINING:
                // Pipeline must empty before halting
                if (pipelineIdle)
                    runState_next = uhcs_pkg::UHCS_HALTED;
            default:
                runState_next = uhcs_pkg::UHCS_HALTED;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (softReset)
        begin
            runState_reg <= uhcs_pkg::UHCS_HALTED;
            halted_reg <= 1'b1;
        end
        else
        begin
            runState_reg <= runState_next;
            halted_reg <= (runState_next == uhcs_pkg::UHCS_HALTED) && !runReg;
        end
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    // Wrap point per list size: bit 13 for 1024, 12 for 512, 11 for 256
    wire logic [3:0] wrapBit = (frameListSize == 2'h0) ? 4'hd :
                               (frameListSize == 2'h1) ? 4'hc : 4'hb;
    wire logic wrapNow = frameCounter[wrapBit];
    wire logic rollover = (wrapNow != lastWrap_reg);
    wire logic [5:0] eventSet = {doorbellDone, hostAccessFault, rollover,
                                 portChange, transferError, transferDone};
    // Read-only advance flag kept out of the write-one mask
    wire logic [5:0] clearMask = stsWrite ? {1'b0, regWdata[4:0]} : 6'h00;

    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : gEvent
            // Set wins over a simultaneous clear
            assign events_next[g] = eventSet[g] || (events_reg[g] && !clearMask[g]);
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (softReset)
        begin
            events_reg <= 6'h00;
            asyncAct_reg <= 1'b0;
            periodicAct_reg <= 1'b0;
            empty_reg <= 1'b0;
            lastWrap_reg <= 1'b0;
        end
        else
        begin
            events_reg <= events_next;
            // Status tracks the scheduler gated by the enable, so it may lag
            asyncAct_reg <= asyncRunning && asyncEnable;
            periodicAct_reg <= periodicRunning && periodicEnable;
            empty_reg <= asyncEmpty;
            lastWrap_reg <= wrapNow;
        end
    end

    // ------------------------------------------------------------
    // Readback and outputs
    // ------------------------------------------------------------
    wire logic [31:0] cmdView = {8'h00, interruptThreshold, 8'h00,
                                 1'b0, doorbell_reg, asyncEnable, periodicEnable,
                                 frameListSize, resetBusy, runReg};
    wire logic [31:0] stsView = {16'h0000, asyncAct_reg, periodicAct_reg, empty_reg,
                                 halted_reg, 6'h00, events_reg};
    wire logic [31:0] readMux = cmdRead ? cmdView : (stsRead ? stsView : 32'h00000000);
    // List index takes bits N down to 3 of the frame counter
    wire logic [9:0] indexNext = (frameListSize == 2'h0) ? frameCounter[12:3] :
                                 (frameListSize == 2'h1) ? {1'b0, frameCounter[11:3]} :
                                 {2'h0, frameCounter[10:3]};

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            regRdata <= 32'h00000000;
            runEnable <= 1'b0;
            listIndex <= 10'h000;
            evictRequest <= 1'b0;
            coreReset <= 1'b0;
            companionOwnership <= 1'b1;
        end
        else
        begin
            regRdata <= regRead ? readMux : regRdata;
            runEnable <= runReg && !resetBusy;
            listIndex <= indexNext;
            evictRequest <= doorbell_reg && !doorbellDone;
            // Core reset reaches pipelines only, never port signalling
            coreReset <= resetBusy;
            companionOwnership <= resetBusy ? 1'b1 : companionOwnership;
        end
    end
endmodule : usb_host_command_status
